// ===== rtl/crtc_core.v
// Calendar clock core: key lock, validated writes, BCD counting, timestamp
`timescale 1ns/10ps
`default_nettype none
`include "crtc_map.vh"
module crtc_core #(
   parameter SLOW_DIV = `CRTC_SLOW_DIV,
   parameter GP_W     = 16
) (
   input  wire            sys_clk,
   input  wire            nrst,
   input  wire            slow_external_osc,
   input  wire            slow_internal_osc,
   input  wire            fast_external_osc,
   input  wire            timestamp_pin,
   input  wire            key_wr,
   input  wire [7:0]      key_data,
   input  wire            ctrl_wr,
   input  wire [4:0]      ctrl_data,
   input  wire            time_wr,
   input  wire [23:0]     time_data,
   input  wire            date_wr,
   input  wire [31:0]     date_data,
   input  wire            irq_flag_clear,
   output reg  [23:0]     time_q,
   output reg  [31:0]     date_q,
   output reg             hour_mode_select,
   output reg             start,
   output reg  [2:0]      source,
   output reg             locked,
   output reg  [23:0]     ts_time,
   output reg  [31:0]     ts_date,
   output reg             ts_flag,
   output reg             write_rejected,
   output reg  [GP_W-1:0] gp_count
);
   // Key lock states, one-hot
   localparam [3:0] ST_LOCK  = 4'h1;
   localparam [3:0] ST_KEY1  = 4'h2;
   localparam [3:0] ST_OPEN  = 4'h4;
   localparam [3:0] ST_RELK  = 4'h8;

   reg  [3:0]  state;       // Lock sequencer
   reg  [3:0]  next_state;  // Its next value
   reg  [23:0] next_time;   // Time after one second
   reg  [31:0] next_date;   // Date after one day
   reg         day_carry;   // Hour wrapped into a new day
   reg         ts_a;        // Timestamp pin, first stage
   reg         ts_b;        // Second stage
   reg         ts_c;        // Delayed copy for edge detect
   wire        unlocked;    // Writes permitted
   wire        time_ok;     // Incoming time fully legal
   wire        date_ok;     // Incoming date fully legal
   wire        slow_sel;    // Calendar source is a slow oscillator
   wire        slow_pin;    // Selected slow oscillator pin
   wire        sec_tick;    // One-second enable
   wire        gp_tick;     // Fast oscillator edge enable
   wire        ts_edge;     // Timestamp rising edge

   // BCD byte inside [lo, hi] with both digits decimal
   function bcd_rng;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         bcd_rng = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
      end
   endfunction

   // BCD increment of a byte, digit carry included
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // Hour legality depends on the hour mode
   function hour_ok;
      input [7:0] h;
      input       m24;
      begin
         if (m24)
            hour_ok = bcd_rng(h, 8'h00, 8'h23); // [R06]
         else
            hour_ok = (h[7:6] == 2'b00) && bcd_rng({3'b000, h[4:0]}, 8'h01, 8'h12); // [R07]
      end
   endfunction

   // Last day of a month; only two-digit years, so every fourth is leap
   function [7:0] month_len;
      input [7:0] mon;
      input [7:0] yr;
      reg         leap;
      begin
         leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
         case (mon)
            8'h02:   month_len = leap ? 8'h29 : 8'h28; // [R09]
            8'h04,
            8'h06,
            8'h09,
            8'h11:   month_len = 8'h30;
            default: month_len = 8'h31;
         endcase
      end
   endfunction

   assign unlocked = state[2];

   // Whole-word validity; one bad field rejects all of it [R02]
   assign time_ok = bcd_rng(time_data[`CRTC_T_SEC], 8'h00, 8'h59) // [R05]
                 && bcd_rng(time_data[`CRTC_T_MIN], 8'h00, 8'h59) // [R05]
                 && hour_ok(time_data[`CRTC_T_HOUR], hour_mode_select);
   assign date_ok = bcd_rng(date_data[`CRTC_D_WEEK], 8'h00, 8'h06) // [R04]
                 && bcd_rng(date_data[`CRTC_D_DAY], 8'h01, 8'h31) // [R03]
                 && bcd_rng(date_data[`CRTC_D_MONTH], 8'h01, 8'h12) // [R03]
                 && bcd_rng(date_data[`CRTC_D_YEAR], 8'h00, 8'h99); // [R03]

   // Only the slow oscillators drive the calendar [R13]
   assign slow_sel = (source == `CRTC_SRC_SLOW_EXT) || (source == `CRTC_SRC_SLOW_INT);
   assign slow_pin = (source == `CRTC_SRC_SLOW_INT) ? slow_internal_osc : slow_external_osc;

   // Seconds divider from the selected slow pin; no sleep gating [R18]
   crtc_tick #(
      .DIV (SLOW_DIV),
      .W   (16)
   ) u_sec (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .osc_pin (slow_pin),
      .enable  (start && slow_sel),
      .tick    (sec_tick)
   );

   // Fast oscillator serves only as a plain edge counter [R13]
   crtc_tick #(
      .DIV (1),
      .W   (1)
   ) u_gp (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .osc_pin (fast_external_osc),
      .enable  (start && (source == `CRTC_SRC_FAST_EXT)),
      .tick    (gp_tick)
   );

   // Lock sequencer transitions on key writes
   always @*
   begin
      next_state = state;
      if (key_wr)
      begin
         case (state)
            ST_LOCK: next_state = (key_data == `CRTC_KEY_FIRST) ? ST_KEY1 : ST_LOCK;
            // Exact pair needed to open [R11]
            ST_KEY1: next_state = (key_data == `CRTC_KEY_UNLOCK) ? ST_OPEN : ST_LOCK;
            ST_OPEN: next_state = (key_data == `CRTC_KEY_FIRST) ? ST_RELK : ST_OPEN;
            // Any second value but the unlock value closes again [R12]
            ST_RELK: next_state = (key_data == `CRTC_KEY_UNLOCK) ? ST_OPEN : ST_LOCK;
            default: next_state = ST_LOCK;
         endcase
      end
   end

   // Locked from reset onward [R10]
   always @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         state  <= ST_LOCK; // [R10]
         locked <= 1'b1;
      end
      else
      begin
         state  <= next_state;
         locked <= !next_state[2];
      end
   end

   // One-second advance of the time word [R19]
   always @*
   begin
      next_time = time_q;
      day_carry = 1'b0;
      if (time_q[`CRTC_T_SEC] != 8'h59)
         next_time[`CRTC_T_SEC] = bcd_inc(time_q[`CRTC_T_SEC]);
      else
      begin
         next_time[`CRTC_T_SEC] = 8'h00;
         if (time_q[`CRTC_T_MIN] != 8'h59)
            next_time[`CRTC_T_MIN] = bcd_inc(time_q[`CRTC_T_MIN]);
         else
         begin
            next_time[`CRTC_T_MIN] = 8'h00;
            if (hour_mode_select)
            begin
               // Plain 00..23 [R08]
               day_carry = (time_q[`CRTC_T_HOUR] == 8'h23);
               next_time[`CRTC_T_HOUR] = day_carry ? 8'h00 : bcd_inc(time_q[`CRTC_T_HOUR]);
            end
            else if (time_q[20:16] == 5'h11)
            begin
               // 11 rolls to 12 and flips the half; PM11 to AM12 is midnight [R08]
               day_carry = time_q[21];
               next_time[`CRTC_T_HOUR] = {2'b00, !time_q[21], 5'h12};
            end
            else if (time_q[20:16] == 5'h12)
               next_time[`CRTC_T_HOUR] = {2'b00, time_q[21], 5'h01}; // [R07]
            else
               next_time[`CRTC_T_HOUR] = bcd_inc({3'b000, time_q[20:16]})
                                         | {2'b00, time_q[21], 5'h00}; // Keep PM bit
         end
      end
   end

   // One-day advance of the date word [R19]
   always @*
   begin
      next_date = date_q;
      next_date[`CRTC_D_WEEK] = (date_q[`CRTC_D_WEEK] == 8'h06) ? 8'h00
                                : bcd_inc(date_q[`CRTC_D_WEEK]); // [R04]
      if (date_q[`CRTC_D_DAY] < month_len(date_q[`CRTC_D_MONTH], date_q[`CRTC_D_YEAR]))
         next_date[`CRTC_D_DAY] = bcd_inc(date_q[`CRTC_D_DAY]);
      else
      begin
         next_date[`CRTC_D_DAY] = 8'h01;
         if (date_q[`CRTC_D_MONTH] != 8'h12)
            next_date[`CRTC_D_MONTH] = bcd_inc(date_q[`CRTC_D_MONTH]);
         else
         begin
            next_date[`CRTC_D_MONTH] = 8'h01;
            // Year 99 wraps to 00
            next_date[`CRTC_D_YEAR] = (date_q[`CRTC_D_YEAR] == 8'h99) ? 8'h00
                                      : bcd_inc(date_q[`CRTC_D_YEAR]);
         end
      end
   end

   // Control word; ignored while locked [R10]
   always @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         hour_mode_select <= 1'b0;
         start            <= 1'b0;
         source           <= `CRTC_SRC_RST;
      end
      else if (ctrl_wr && unlocked)
      begin
         hour_mode_select <= ctrl_data[`CRTC_CTL_H24];
         start            <= ctrl_data[`CRTC_CTL_START];
         source           <= ctrl_data[`CRTC_CTL_SRC_HI:`CRTC_CTL_SRC_LO];
      end
   end

   // Calendar registers; an accepted write beats the tick in that cycle
   always @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         time_q <= `CRTC_TIME_RST; // [R01]
         date_q <= `CRTC_DATE_RST; // [R01]
      end
      else
      begin
         if (time_wr && unlocked && time_ok)
            time_q <= time_data; // [R02]
         else if (sec_tick)
            time_q <= next_time;
         if (date_wr && unlocked && date_ok)
            date_q <= date_data; // [R02]
         else if (sec_tick && day_carry)
            date_q <= next_date;
      end
   end

   // Pulse for any write dropped by the lock or by a bad field
   always @(posedge sys_clk)
   begin
      if (!nrst)
         write_rejected <= 1'b0;
      else
         write_rejected <= ((time_wr || date_wr || ctrl_wr) && !unlocked)
                        || (time_wr && unlocked && !time_ok)
                        || (date_wr && unlocked && !date_ok);
   end

   // General counter on fast oscillator edges
   always @(posedge sys_clk)
   begin
      if (!nrst)
         gp_count <= {GP_W{1'b0}};
      else if (gp_tick)
         gp_count <= gp_count + {{(GP_W-1){1'b0}}, 1'b1}; // [R13]
   end

   // Timestamp pin synchroniser
   always @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         ts_a <= 1'b0;
         ts_b <= 1'b0;
         ts_c <= 1'b0;
      end
      else
      begin
         ts_a <= timestamp_pin;
         ts_b <= ts_a;
         ts_c <= ts_b;
      end
   end

   assign ts_edge = ts_b && !ts_c;

   // Capture and flag together; a set in the clearing cycle wins
   always @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         ts_time <= 24'h000000;
         ts_date <= 32'h00000000;
         ts_flag <= 1'b0;
      end
      else if (ts_edge)
      begin
         ts_time <= time_q; // [R17]
         ts_date <= date_q; // [R17]
         ts_flag <= 1'b1;   // [R17]
      end
      else if (irq_flag_clear)
         ts_flag <= 1'b0; // Clear is never locked [R10]
   end
endmodule
`default_nettype wire

// ===== pkg/crtc_map.vh
// Key values, field positions, codes and reset values of the calendar clock
// Overview of operation
// R01: Time and date held as BCD fields
// R02: Any illegal field discards the whole write
// R03: Year 0-99, month 1-12, day 1-31 valid
// R04: Weekday 0-6, zero meaning Sunday
// R05: Seconds and minutes valid 0-59 only
// R06: Hour mode one counts hours 00-23
// R07: Hour mode zero counts 1-12, top bit PM
// R08: 12h midnight 0x12, noon 0x32, PM 0x21-0x31
// R09: February gains a day in leap years
// R10: Registers locked after reset except key, clear
// R11: Key 0xCA then 0x53 unlocks
// R12: Key 0xCA then other value relocks
// R13: Slow clocks run calendar, fast only counts
// R14: Software follows the documented init order
// R15: Software waits for slow oscillator to settle
// R16: Software skips init if already running
// R17: Timestamp edge captures time, raises flag
// R18: Counting continues in every sleep mode
// R19: Carries ripple seconds through years, 99 wraps
`ifndef CRTC_MAP_VH
`define CRTC_MAP_VH
// Key sequence values
`define CRTC_KEY_FIRST   8'hca
`define CRTC_KEY_UNLOCK  8'h53
// Control word fields
`define CRTC_CTL_H24     0
`define CRTC_CTL_START   1
`define CRTC_CTL_SRC_LO  2
`define CRTC_CTL_SRC_HI  4
// Clock source codes
`define CRTC_SRC_SLOW_EXT 3'b000
`define CRTC_SRC_SLOW_INT 3'b010
`define CRTC_SRC_FAST_EXT 3'b100
// Time word byte positions {hour, minute, second}
`define CRTC_T_SEC  7:0
`define CRTC_T_MIN  15:8
`define CRTC_T_HOUR 23:16
// Date word byte positions {year, month, day, weekday}
`define CRTC_D_WEEK  7:0
`define CRTC_D_DAY   15:8
`define CRTC_D_MONTH 23:16
`define CRTC_D_YEAR  31:24
// Reset values
`define CRTC_TIME_RST 24'h120000
`define CRTC_DATE_RST 32'h00010100
`define CRTC_SRC_RST  3'b000
// Slow oscillator edges per second
`define CRTC_SLOW_DIV 32768
`endif

// ===== rtl/crtc_tick.v
// Pin-edge synchroniser and divider producing one-cycle tick enables
`timescale 1ns/10ps
`default_nettype none
module crtc_tick #(
   parameter DIV = 32768,
   parameter W   = 16
) (
   input  wire sys_clk,
   input  wire nrst,
   input  wire osc_pin,
   input  wire enable,
   output reg  tick
);
   localparam integer LASTI = DIV - 1;
   localparam [W-1:0] LAST  = LASTI[W-1:0];

   reg         sync_a;   // First stage, read only by second
   reg         sync_b;   // Second stage
   reg         sync_c;   // Delayed copy for edge detection
   reg [W-1:0] count;    // Edges seen in current period

   // Two-flop synchroniser then rising-edge detect
   always @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end
      else
      begin
         sync_a <= osc_pin;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Divide edges; held at zero while disabled so a restart begins clean
   always @(posedge sys_clk)
   begin
      if (!nrst || !enable)
      begin
         count <= {W{1'b0}};
         tick  <= 1'b0;
      end
      else if (sync_b && !sync_c)
      begin
         // Full period reached
         if (count == LAST)
         begin
            count <= {W{1'b0}};
            tick  <= 1'b1;
         end
         else
         begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
         end
      end
      else
         tick <= 1'b0;
   end
endmodule
`default_nettype wire

// ===== testbench/crtc_chk.sv
// Port checker of lock, write screening and timestamp flag
`timescale 1ns/10ps
`default_nettype none
module crtc_chk (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        timestamp_pin,
   input wire logic        key_wr,
   input wire logic [7:0]  key_data,
   input wire logic        ctrl_wr,
   input wire logic        time_wr,
   input wire logic [23:0] time_data,
   input wire logic        date_wr,
   input wire logic [31:0] date_data,
   input wire logic        irq_flag_clear,
   input wire logic [23:0] time_q,
   input wire logic        hour_mode_select,
   input wire logic        start,
   input wire logic [2:0]  source,
   input wire logic        locked,
   input wire logic        ts_flag,
   input wire logic        write_rejected
);
   // One domain, so one clock and reset for all
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // BCD byte within limit, low digit decimal
   function automatic logic ok(input logic [7:0] v, input logic [7:0] lim);
      ok = (v <= lim) && (v[3:0] <= 4'h9);
   endfunction

   a_reset_vals: assert property ($rose(nrst) |-> time_q == 24'h120000 && locked)
      else $error("reset values wrong");
   a_key_open: assert property (key_wr && key_data == 8'hca ##1 key_wr && key_data == 8'h53
      |=> !locked) else $error("key sequence did not unlock");
   a_key_close: assert property (key_wr && key_data == 8'hca ##1 key_wr && key_data != 8'h53
      |=> locked) else $error("key sequence did not lock");
   a_lock_drop: assert property (locked && (time_wr || date_wr) |=> write_rejected)
      else $error("locked write not dropped");
   a_ctrl_lock: assert property (locked && ctrl_wr |=> $stable(start) && $stable(source)
      && $stable(hour_mode_select)) else $error("locked control changed");
   a_bad_date: assert property (!locked && date_wr && (date_data[23:16] > 8'h12
      || date_data[15:8] > 8'h31 || date_data[7:0] > 8'h06) |=> write_rejected)
      else $error("bad date kept");
   a_bad_ms: assert property (!locked && time_wr && (time_data[7:0] > 8'h59
      || time_data[15:8] > 8'h59) |=> write_rejected) else $error("bad time kept");
   a_bad_hour: assert property (!locked && time_wr && hour_mode_select
      && time_data[23:16] > 8'h23 |=> write_rejected) else $error("bad hour kept");
   a_good_time: assert property (!locked && time_wr && hour_mode_select
      && ok(time_data[23:16], 8'h23) && ok(time_data[15:8], 8'h59) && ok(time_data[7:0], 8'h59)
      |=> time_q == $past(time_data)) else $error("good time not stored");
   a_ts_hold: assert property (ts_flag && !irq_flag_clear |=> ts_flag)
      else $error("timestamp flag lost");
   a_ts_clear: assert property (irq_flag_clear && !timestamp_pin && !$past(timestamp_pin)
      && !$past(timestamp_pin, 2) && !$past(timestamp_pin, 3) |=> !ts_flag)
      else $error("timestamp flag not cleared");
   a_ts_cause: assert property ($rose(ts_flag) |-> $past(timestamp_pin, 2)
      || $past(timestamp_pin, 3) || $past(timestamp_pin, 4) || $past(timestamp_pin, 5))
      else $error("timestamp flag without pin edge");
endmodule
// Watch every instance of the core
bind crtc_core crtc_chk chk_u (.*);
`default_nettype wire

// ===== testbench/tb_crtc_core.sv
// Self-checking bench of the calendar clock core
`timescale 1ns/10ps
`default_nettype none
module tb_crtc_core;
   logic        sys_clk = 0;       // Bench clock
   logic        nrst = 0;          // Reset held low at start
   logic        slow_external_osc = 0, slow_internal_osc = 0, fast_external_osc = 0;
   logic        timestamp_pin = 0, key_wr = 0, ctrl_wr = 0, time_wr = 0, date_wr = 0;
   logic        irq_flag_clear = 0;
   logic [7:0]  key_data = 8'h00;
   logic [4:0]  ctrl_data = 5'h00;
   logic [23:0] time_data = 24'h000000;
   logic [31:0] date_data = 32'h00000000;
   wire  [23:0] time_q, ts_time;
   wire  [31:0] date_q, ts_date;
   wire         hour_mode_select, start, locked, ts_flag, write_rejected;
   wire  [2:0]  source;
   wire  [15:0] gp_count;
   int          err_count = 0; // Mismatches
   int          compares = 0;  // Comparisons made
   logic        rej;           // Reject pulse seen by last write
   logic [23:0] t0;            // Time before a step
   // Short divider keeps each tick at four edges
   crtc_core #(.SLOW_DIV(4), .GP_W(16)) dut_u (.*);

   always #4 sys_clk = ~sys_clk;

   // Control word, time, date per tick case, and expected results
   logic [4:0]  cw [6] = '{5'b00011, 5'b00010, 5'b00010, 5'b00010, 5'b01011, 5'b00010};
   logic [23:0] tt [6] = '{24'h235959, 24'h115959, 24'h315959, 24'h315959, 24'h235959,
                           24'h125959};
   logic [31:0] dd [6] = '{32'h99123106, 32'h24022803, 32'h24022803, 32'h23022803,
                           32'h23043005, 32'h23043005};
   logic [23:0] et [6] = '{24'h000000, 24'h320000, 24'h120000, 24'h120000, 24'h000000,
                           24'h010000};
   logic [31:0] ed [6] = '{32'h00010100, 32'h24022803, 32'h24022904, 32'h23030104,
                           32'h23050106, 32'h23043005};
   // Illegal writes: select and word
   int          bs [10] = '{1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
   logic [31:0] bd [10] = '{24'h240000, 24'h006000, 24'h000060, 24'h00005a, 32'h00130101,
                            32'h00013201, 32'h00010001, 32'h00010107, 32'h00000101, 32'ha0010101};

   // Compare and count
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         err_count++;
      end
   endtask

   // Counts, verdict and end of run
   task print_verdict;
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Two key bytes back to back
   task key2(input logic [7:0] a, input logic [7:0] b);
      @(negedge sys_clk);
      key_wr = 1;
      key_data = a;
      @(negedge sys_clk);
      key_data = b;
      @(negedge sys_clk);
      key_wr = 0;
      @(negedge sys_clk);
   endtask

   // One-cycle write: 0 control, 1 time, 2 date; catches the reject pulse
   task wr(input int sel, input logic [31:0] d);
      @(negedge sys_clk);
      ctrl_wr = (sel == 0);
      time_wr = (sel == 1);
      date_wr = (sel == 2);
      ctrl_data = d[4:0];
      time_data = d[23:0];
      date_data = d;
      @(negedge sys_clk);
      {ctrl_wr, time_wr, date_wr} = 3'b000;
      rej = write_rejected;
   endtask

   // Rising edges on the slow pins, or the fast pin, then settle
   task edges(input int n, input bit fast);
      repeat (n)
      begin
         @(negedge sys_clk);
         if (fast) fast_external_osc = 1;
         else {slow_external_osc, slow_internal_osc} = 2'b11;
         repeat (4) @(negedge sys_clk);
         {fast_external_osc, slow_external_osc, slow_internal_osc} = 3'b000;
         repeat (4) @(negedge sys_clk);
      end
      repeat (8) @(negedge sys_clk);
   endtask

   // Integer to BCD byte
   function automatic logic [7:0] bcd(input int v);
      bcd = 8'((v / 10) * 16 + v % 10);
   endfunction

   // Cuts a hang short
   initial
   begin
      #(8 * 40000);
      err_count++;
      print_verdict;
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'hcbae));
      repeat (20) @(negedge sys_clk);
      nrst = 1;
      @(negedge sys_clk);
      chk("locked", locked, 1);
      chk("time_q", time_q, 24'h120000);
      wr(1, 24'h010203);
      chk("reject", rej, 1);
      chk("time_q", time_q, 24'h120000);
      wr(0, 5'b00011);
      chk("start", start, 0);
      key2(8'hca, 8'h53);
      chk("locked", locked, 0);
      $display("done: lock");
      // Illegal fields in 24-hour form, then 12-hour hours
      wr(0, 5'b00001);
      for (int i = 0; i < 10; i++)
      begin
         wr(bs[i], bd[i]);
         chk("reject", rej, 1);
         chk("time_q", time_q, 24'h120000);
         chk("date_q", date_q, 32'h00010100);
      end
      wr(0, 5'b00000);
      wr(1, 24'h130000);
      chk("reject", rej, 1);
      wr(1, 24'h000000);
      chk("reject", rej, 1);
      $display("done: screening");
      // Random legal and illegal times in 24-hour form
      wr(0, 5'b00001);
      repeat (16)
      begin
         t0 = {bcd($urandom % 24), bcd($urandom % 60), bcd($urandom % 60)};
         wr(1, t0);
         chk("reject", rej, 0);
         chk("time_q", time_q, t0);
         wr(1, {t0[23:8], 8'h60 + 8'($urandom % 32)});
         chk("reject", rej, 1);
         chk("time_q", time_q, t0);
      end
      $display("done: random writes");
      // Carries, hour encoding, leap years, month length
      for (int i = 0; i < 6; i++)
      begin
         wr(0, cw[i]); // Mode and source first, pins quiet
         chk("ctrl", {source, start, hour_mode_select}, cw[i]);
         wr(1, tt[i]);
         wr(2, dd[i]);
         edges(4, 0);
         chk("time_q", time_q, et[i]);
         chk("date_q", date_q, ed[i]);
      end
      $display("done: calendar");
      // Fast source counts edges and leaves the calendar still
      wr(0, 5'b10011); // Control only, time and date kept
      edges(5, 1);
      edges(4, 0);
      chk("gp_count", gp_count, 16'h0005);
      chk("time_q", time_q, et[5]);
      chk("date_q", date_q, ed[5]);
      $display("done: fast source");
      // Timestamp capture, relock, clear while locked
      timestamp_pin = 1;
      repeat (8) @(negedge sys_clk);
      timestamp_pin = 0;
      chk("ts_flag", ts_flag, 1);
      chk("ts_time", ts_time, et[5]);
      chk("ts_date", ts_date, ed[5]);
      key2(8'hca, 8'h00);
      chk("locked", locked, 1);
      wr(2, 32'h01010101);
      chk("reject", rej, 1);
      repeat (4) @(negedge sys_clk);
      irq_flag_clear = 1;
      @(negedge sys_clk);
      irq_flag_clear = 0;
      @(negedge sys_clk);
      chk("ts_flag", ts_flag, 0);
      $display("done: timestamp");
      print_verdict;
   end
endmodule
`default_nettype wire
